/* shared/pll_ctrl_pkg.sv */
// constants and types for the system pll control block
package pll_ctrl_pkg;
  // register offsets
  localparam logic [7:0] CTRL_OFS = 8'h0c;
  localparam logic [7:0] CFG0_OFS = 8'h10;
  // control register bit positions
  localparam int GATE_BIT  = 31;
  localparam int LOCK1_BIT = 5;
  localparam int LOCK0_BIT = 4;
  localparam int BYP1_BIT  = 3;
  localparam int BYP0_BIT  = 2;
  localparam int RST1_BIT  = 1;
  localparam int RST0_BIT  = 0;
  // stage 0 config field positions
  localparam int RANGE_LSB = 20;
  localparam int DIVQ_LSB  = 16;
  localparam int DIVR_LSB  = 8;
  localparam int DIVF_LSB  = 0;
  // reset values
  localparam logic       GATE_RST  = 1'b1;
  localparam logic       BYP_RST   = 1'b1;
  localparam logic       SRST_RST  = 1'b1;
  localparam logic [2:0] RANGE_RST = 3'h0;
  localparam logic [2:0] DIVQ_RST  = 3'h0;
  localparam logic [4:0] DIVR_RST  = 5'h00;
  localparam logic [7:0] DIVF_RST  = 8'h00;
  // filter range code meaning loop filter bypass
  localparam logic [2:0] RANGE_BYPASS = 3'h0;
  // gate state machine
  typedef enum logic {GATE_STOPPED, GATE_RUNNING} gate_state_e;
endpackage : pll_ctrl_pkg

/* shared/gate_if.sv */
// carrier between the control block and its clock gate
`timescale 1ns/10ps
interface gate_if;
  logic clk_src;
  logic gate_req;
  logic clk_out;
  logic running;
  modport ctrl (output clk_src, output gate_req, input clk_out, input running);
  modport gate (input clk_src, input gate_req, output clk_out, output running);
endinterface : gate_if

/* verilog/glitch_free_gate.sv */
// glitch-free gate for the clocks derived from the system pll
`timescale 1ns/10ps
module glitch_free_gate
  import pll_ctrl_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  gate_if.gate      gif
);
  gate_state_e state_reg, state_next;
  logic        out_reg, out_next;

  // state only moves while the source is low, so no pulse is ever cut short
  always_comb begin
    state_next = state_reg;
    // R1: stop when low
    if (state_reg == GATE_RUNNING && gif.gate_req && !gif.clk_src) begin
      state_next = GATE_STOPPED;
    // R2: start when low
    end else if (state_reg == GATE_STOPPED && !gif.gate_req && !gif.clk_src) begin
      state_next = GATE_RUNNING;
    end
    out_next = (state_next == GATE_RUNNING) ? gif.clk_src : 1'b0;
  end

  // register state and output
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg <= GATE_STOPPED;
      out_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      out_reg   <= out_next;
    end
  end

  assign gif.clk_out = out_reg;
  assign gif.running = (state_reg == GATE_RUNNING);

  AST_GATE_STOPPED_LOW: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R1
    (state_reg == GATE_STOPPED && gif.gate_req) |=> !out_reg)
    else $error("gated clock active while stopped");
  AST_GATE_NO_RUNT: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R2
    $rose(out_reg) |-> $past(gif.clk_src) && $past(gif.running, 1) == gif.running)
    else $error("runt pulse on gated clock");
  CV_GATE_START: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(gif.running));
  CV_GATE_STOP: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    $fell(gif.running));
endmodule : glitch_free_gate

/* verilog/system_pll_control_config.sv */
// control and configuration logic of the two-stage system clock pll
//
// Notes on behaviour
// R1: gate bit set, its reset state, stops all derived clocks glitch-free
// R2: clearing the gate bit restarts derived clocks with no runt pulse
// R3: software clears the gate only once the pll is stable
// R4: lock flags read on bits 5 and 4, reset to zero
// R5: lock inputs are synchronised before entering the control register
// R6: software uses lock flags only for test and status
// R7: either bypass bit powers its stage down and routes input to output
// R8: stage 1 bypass, reset state, makes final pair follow stage 0 node
// R9: stage 0 bypass, reset state, makes stage 0 node follow the reference
// R10: software sets both bypass bits for full reference pass-through
// R11: stage 1 reset powers down stage 1 and holds final pair low
// R12: stage 0 reset powers down stage 0 and holds its node low
// R13: filter range code zero is bypass, 1..7 rising ranges, resets zero
// R14: software picks the highest valid filter range
// R15: output divider is two to the field; code seven not to be written
// R16: software keeps stage 0 node within its frequency limits
// R17: reference divider is field plus one, resets to zero
// R18: feedback divider is field plus one, resets to zero
// R19: software keeps raw and divided reference within 5 to 200 mhz
// R20: software keeps the stage 0 oscillator within 350 to 700 mhz
// R21: model gives oscillator and node frequency from the divider fields
//
// Added by the designer: strobed register access.
`timescale 1ns/10ps
module system_pll_control_config
  import pll_ctrl_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int FREQ_W = 32
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [31:0]       wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [31:0]       rdata_o,
  input  wire logic              ref_clk_i,
  input  wire logic              core0_clk_i,
  input  wire logic              core1_clk_i,
  input  wire logic              lock0_async_i,
  input  wire logic              lock1_async_i,
  input  wire logic [FREQ_W-1:0] ref_freq_khz_i,
  output logic                   first_stage_powerdown_o,
  output logic                   second_stage_powerdown_o,
  output logic                   filter_bypass_o,
  output logic      [2:0]        first_stage_filter_range_o,
  output logic      [2:0]        first_stage_output_divider_o,
  output logic      [4:0]        first_stage_reference_divider_o,
  output logic      [7:0]        first_stage_feedback_divider_o,
  output logic                   first_stage_output_node_o,
  output logic                   final_pll_output_o,
  output logic                   final_pll_output_inverted_o,
  output logic                   derived_clk_o,
  output logic                   derived_clk_running_o,
  output logic      [FREQ_W-1:0] first_stage_oscillator_khz_o,
  output logic      [FREQ_W-1:0] first_stage_output_node_khz_o
);

  ////////////////////////////////////////////////////////////////////////
  // register file

  logic       gate_reg, gate_next;
  logic       byp1_reg, byp1_next;
  logic       byp0_reg, byp0_next;
  logic       rst1_reg, rst1_next;
  logic       rst0_reg, rst0_next;
  logic [2:0] range_reg, range_next;
  logic [2:0] divq_reg, divq_next;
  logic [4:0] divr_reg, divr_next;
  logic [7:0] divf_reg, divf_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] lock_meta_reg;
  logic [1:0] lock_sync_reg;
  logic [1:0] lock_async;
  logic       sel_ctrl;
  logic       sel_cfg0;

  assign sel_ctrl   = (addr_i == ADDR_W'(CTRL_OFS));
  assign sel_cfg0   = (addr_i == ADDR_W'(CFG0_OFS));
  assign lock_async = {lock1_async_i, lock0_async_i};

  // register writes and read data; unmapped reads return zero
  always_comb begin
    gate_next  = gate_reg;
    byp1_next  = byp1_reg;
    byp0_next  = byp0_reg;
    rst1_next  = rst1_reg;
    rst0_next  = rst0_reg;
    range_next = range_reg;
    divq_next  = divq_reg;
    divr_next  = divr_reg;
    divf_next  = divf_reg;
    rdata_next = 32'h0000_0000;
    if (wr_i && sel_ctrl) begin
      gate_next = wdata_i[GATE_BIT];
      byp1_next = wdata_i[BYP1_BIT];
      byp0_next = wdata_i[BYP0_BIT];
      rst1_next = wdata_i[RST1_BIT];
      rst0_next = wdata_i[RST0_BIT];
    end else if (wr_i && sel_cfg0) begin
      range_next = wdata_i[RANGE_LSB +: 3];
      // R15: code seven kept as written
      divq_next  = wdata_i[DIVQ_LSB +: 3];
      divr_next  = wdata_i[DIVR_LSB +: 5];
      divf_next  = wdata_i[DIVF_LSB +: 8];
    end
    if (rd_i && sel_ctrl) begin
      rdata_next[GATE_BIT]  = gate_reg;
      // R4: lock flags readback
      rdata_next[LOCK1_BIT] = lock_sync_reg[1];
      rdata_next[LOCK0_BIT] = lock_sync_reg[0];
      rdata_next[BYP1_BIT]  = byp1_reg;
      rdata_next[BYP0_BIT]  = byp0_reg;
      rdata_next[RST1_BIT]  = rst1_reg;
      rdata_next[RST0_BIT]  = rst0_reg;
    end else if (rd_i && sel_cfg0) begin
      rdata_next[RANGE_LSB +: 3] = range_reg;
      rdata_next[DIVQ_LSB +: 3]  = divq_reg;
      rdata_next[DIVR_LSB +: 5]  = divr_reg;
      rdata_next[DIVF_LSB +: 8]  = divf_reg;
    end
  end

  // register the file; reset leaves both stages held and bypassed
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      // R1: gate set at reset
      gate_reg  <= GATE_RST;
      byp1_reg  <= BYP_RST;
      byp0_reg  <= BYP_RST;
      rst1_reg  <= SRST_RST;
      rst0_reg  <= SRST_RST;
      // R13: range resets to bypass
      range_reg <= RANGE_RST;
      divq_reg  <= DIVQ_RST;
      // R17: reference divider reset
      divr_reg  <= DIVR_RST;
      // R18: feedback divider reset
      divf_reg  <= DIVF_RST;
      rdata_reg <= 32'h0000_0000;
    end else begin
      gate_reg  <= gate_next;
      byp1_reg  <= byp1_next;
      byp0_reg  <= byp0_next;
      rst1_reg  <= rst1_next;
      rst0_reg  <= rst0_next;
      range_reg <= range_next;
      divq_reg  <= divq_next;
      divr_reg  <= divr_next;
      divf_reg  <= divf_next;
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_o = rdata_reg;

  ////////////////////////////////////////////////////////////////////////
  // lock synchronisers; first stage feeds only the second

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_lock_sync
      // R5: two-flop lock sync
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          lock_meta_reg[gi] <= 1'b0;
          lock_sync_reg[gi] <= 1'b0;
        end else begin
          lock_meta_reg[gi] <= lock_async[gi];
          lock_sync_reg[gi] <= lock_meta_reg[gi];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // stage control to the analog core

  // R7: bypass powers stage down
  assign first_stage_powerdown_o  = rst0_reg | byp0_reg;
  assign second_stage_powerdown_o = rst1_reg | byp1_reg;
  // R13: code zero is filter bypass
  assign filter_bypass_o                 = (range_reg == RANGE_BYPASS);
  assign first_stage_filter_range_o      = range_reg;
  assign first_stage_output_divider_o    = divq_reg;
  assign first_stage_reference_divider_o = divr_reg;
  assign first_stage_feedback_divider_o  = divf_reg;

  ////////////////////////////////////////////////////////////////////////
  // output clock path

  logic node_reg, node_next;
  logic final_reg, final_next;
  logic finalb_reg, finalb_next;

  // reset wins over bypass, bypass wins over the core output
  always_comb begin
    // R12: stage 0 held low
    if (rst0_reg) begin
      node_next = 1'b0;
    // R9: node follows reference
    end else if (byp0_reg) begin
      node_next = ref_clk_i;
    end else begin
      node_next = core0_clk_i;
    end
    // R11: final pair held low
    if (rst1_reg) begin
      final_next  = 1'b0;
      finalb_next = 1'b0;
    // R8: final follows stage 0 node
    end else if (byp1_reg) begin
      final_next  = node_reg;
      finalb_next = ~node_reg;
    end else begin
      final_next  = core1_clk_i;
      finalb_next = ~core1_clk_i;
    end
  end

  // register the clock path levels
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      node_reg   <= 1'b0;
      final_reg  <= 1'b0;
      finalb_reg <= 1'b0;
    end else begin
      node_reg   <= node_next;
      final_reg  <= final_next;
      finalb_reg <= finalb_next;
    end
  end

  assign first_stage_output_node_o   = node_reg;
  assign final_pll_output_o          = final_reg;
  assign final_pll_output_inverted_o = finalb_reg;

  // derived clocks are gated from the final output
  gate_if gif ();
  assign gif.clk_src  = final_reg;
  assign gif.gate_req = gate_reg;

  glitch_free_gate u_gate (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .gif     (gif.gate)
  );

  assign derived_clk_o         = gif.clk_out;
  assign derived_clk_running_o = gif.running;

  ////////////////////////////////////////////////////////////////////////
  // stage 0 frequency model

  logic [FREQ_W-1:0] dref_khz;
  logic [FREQ_W-1:0] osc_khz;
  logic [FREQ_W-1:0] osc_reg, osc_next;
  logic [FREQ_W-1:0] nodef_reg, nodef_next;

  // R17: divide by field plus one
  assign dref_khz = ref_freq_khz_i / FREQ_W'({1'b0, divr_reg} + 6'h01);
  // R18: multiply by field plus one; wraps past the word width
  assign osc_khz  = FREQ_W'(dref_khz * FREQ_W'({1'b0, divf_reg} + 9'h001));

  // R21: oscillator and node frequency
  always_comb begin
    osc_next = osc_khz;
    if (rst0_reg) begin
      nodef_next = '0;
    end else if (byp0_reg) begin
      nodef_next = ref_freq_khz_i;
    end else begin
      // R15: divide by two to the field
      nodef_next = osc_khz >> divq_reg;
    end
  end

  // register the model words
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      osc_reg   <= '0;
      nodef_reg <= '0;
    end else begin
      osc_reg   <= osc_next;
      nodef_reg <= nodef_next;
    end
  end

  assign first_stage_oscillator_khz_o  = osc_reg;
  assign first_stage_output_node_khz_o = nodef_reg;

  ////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_LOCK_READ: assert property ( // R4
    (rd_i && sel_ctrl) |=> rdata_o[LOCK1_BIT:LOCK0_BIT] == $past(lock_sync_reg))
    else $error("lock flags misreported");
  AST_LOCK_SYNC: assert property ( // R5
    $past(rst_n_i, 2) && $past(rst_n_i) |-> lock_sync_reg == $past(lock_async, 2))
    else $error("lock sync latency wrong");
  AST_BYPASS_PD: assert property ( // R7
    (wr_i && sel_ctrl && wdata_i[BYP0_BIT]) |=> first_stage_powerdown_o)
    else $error("bypass did not power stage down");
  AST_FINAL_FOLLOWS: assert property ( // R8
    (!rst1_reg && byp1_reg) |=> final_reg == $past(node_reg) && finalb_reg != final_reg)
    else $error("final pair not following stage 0 node");
  AST_NODE_REF: assert property ( // R9
    (!rst0_reg && byp0_reg) |=> node_reg == $past(ref_clk_i))
    else $error("stage 0 node not following reference");
  AST_FINAL_LOW: assert property ( // R11
    rst1_reg |=> !final_reg && !finalb_reg)
    else $error("final pair not held low");
  AST_NODE_LOW: assert property ( // R12
    rst0_reg |=> !node_reg)
    else $error("stage 0 node not held low");
  AST_RANGE_BYP: assert property ( // R13
    (wr_i && sel_cfg0 && wdata_i[RANGE_LSB +: 3] == 3'h0) |=> filter_bypass_o)
    else $error("range zero not filter bypass");
  AST_DIVQ: assert property ( // R15
    (!rst0_reg && !byp0_reg && divq_reg == 3'h1) |=> nodef_reg == ($past(osc_khz) >> 1))
    else $error("output divider wrong");
  AST_UNITY_DIV: assert property ( // R21
    (divr_reg == 5'h00 && divf_reg == 8'h00) |=> osc_reg == $past(ref_freq_khz_i))
    else $error("unity dividers change frequency");

  CV_FULL_BYPASS: cover property (!rst0_reg && !rst1_reg && byp0_reg && byp1_reg);
  CV_LOCK0: cover property ($rose(lock_sync_reg[0]));
  CV_PLL_MODE: cover property (!first_stage_powerdown_o && !second_stage_powerdown_o);
endmodule : system_pll_control_config

/* testbench/system_pll_control_config_tb.sv */
// self-checking testbench for the system pll control and config block
`timescale 1ns/10ps
module system_pll_control_config_tb
  import pll_ctrl_pkg::*;
;
  logic        clk_i, rst_n_i, wr_i, rd_i, ref_run, ref_lvl, ref_tog;
  logic        ref_clk_i, core0_clk_i, core1_clk_i, lock0_async_i, lock1_async_i;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i, rdata_o, ref_freq_khz_i, osc_khz, node_khz, rd_val;
  logic        pd0, pd1, fbyp, node, fin, finb, dclk, drun;
  logic [2:0]  range_f, divq_f;
  logic [4:0]  divr_f;
  logic [7:0]  divf_f;
  int          err_count, check_count;

  system_pll_control_config i_system_pll_control_config (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ref_clk_i(ref_clk_i),
    .core0_clk_i(core0_clk_i), .core1_clk_i(core1_clk_i),
    .lock0_async_i(lock0_async_i), .lock1_async_i(lock1_async_i),
    .ref_freq_khz_i(ref_freq_khz_i), .first_stage_powerdown_o(pd0),
    .second_stage_powerdown_o(pd1), .filter_bypass_o(fbyp),
    .first_stage_filter_range_o(range_f), .first_stage_output_divider_o(divq_f),
    .first_stage_reference_divider_o(divr_f), .first_stage_feedback_divider_o(divf_f),
    .first_stage_output_node_o(node), .final_pll_output_o(fin),
    .final_pll_output_inverted_o(finb), .derived_clk_o(dclk),
    .derived_clk_running_o(drun), .first_stage_oscillator_khz_o(osc_khz),
    .first_stage_output_node_khz_o(node_khz));

  //////////////////////////////////////////////////////////////////////////
  // 50 mhz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // free-running reference level, toggled only when asked so path tests stay exact
  always @(posedge clk_i) begin
    if (ref_run) ref_tog <= ~ref_tog;
  end

  // one driver for the reference pin: toggler while running, task level otherwise
  assign ref_clk_i = ref_run ? ref_tog : ref_lvl;

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cycles

  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
    #1;
  endtask : bus_write

  // read data stand only in the cycle after the strobe
  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1 d = rdata_o;
  endtask : bus_read

  // bounded wait on the gate state output
  task automatic wait_run(input logic v);
    int n;
    for (n = 0; n < 40 && drun !== v; n++) cycles(1);
    if (drun !== v) begin
      err_count++;
      $display("BAD at %0t: gate state never changed", $time);
      report_and_stop();
    end
  endtask : wait_run

  //////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    check({29'h0, pd0, pd1, fbyp}, 32'h7, "powerdown or filter bypass after reset");
    check({28'h0, node, fin, finb, drun}, 32'h0, "levels after reset");
    bus_read(CTRL_OFS, rd_val);
    check(rd_val, 32'h8000000f, "control reset value");
    bus_read(CFG0_OFS, rd_val);
    check(rd_val, 32'h0, "config reset value");
    $display("test reset done");
  endtask : test_reset

  // every bypass and reset pattern; reserved and lock bits written high read low
  task automatic test_ctrl_bits();
    for (int i = 0; i < 16; i++) begin
      bus_write(CTRL_OFS, 32'hfffffff0 | i);
      check({31'h0, pd0}, {31'h0, i[0] | i[2]}, "stage 0 powerdown");
      check({31'h0, pd1}, {31'h0, i[1] | i[3]}, "stage 1 powerdown");
      bus_read(CTRL_OFS, rd_val);
      check(rd_val, 32'h80000000 | i, "control readback");
    end
    bus_write(8'h14, 32'hffffffff);
    bus_read(8'h14, rd_val);
    check(rd_val, 32'h0, "unmapped read");
    bus_read(CTRL_OFS, rd_val);
    check(rd_val, 32'h8000000f, "control after unmapped write");
    $display("test control bits done");
  endtask : test_ctrl_bits

  task automatic test_lock();
    @(posedge clk_i) lock0_async_i <= 1'b1;
    cycles(2);
    bus_read(CTRL_OFS, rd_val);
    check(rd_val, 32'h8000001f, "stage 0 lock flag");
    @(posedge clk_i) lock1_async_i <= 1'b1;
    cycles(2);
    bus_read(CTRL_OFS, rd_val);
    check(rd_val, 32'h8000003f, "both lock flags");
    @(posedge clk_i) {lock0_async_i, lock1_async_i} <= 2'b00;
    cycles(2);
    bus_read(CTRL_OFS, rd_val);
    check(rd_val, 32'h8000000f, "lock flags cleared");
    $display("test lock done");
  endtask : test_lock

  // every filter range code, output divider codes 0 to 6, model words
  task automatic test_cfg();
    logic [31:0] d;
    logic [2:0]  q;
    bus_write(CTRL_OFS, 32'h80000008);
    for (int r = 0; r < 8; r++) begin
      q = (r == 7) ? 3'h6 : r[2:0];
      d = {9'h0, r[2:0], 1'b0, q, 3'h0, 5'h01, 8'h09};
      bus_write(CFG0_OFS, d | 32'hff88e000);
      check({31'h0, fbyp}, {31'h0, r == 0}, "filter bypass");
      check({13'h0, range_f, divq_f, divr_f, divf_f}, {13'h0, r[2:0], q, 5'h01, 8'h09},
            "field outputs");
      bus_read(CFG0_OFS, rd_val);
      check(rd_val, d, "config readback");
      cycles(2);
      check(osc_khz, 32'd500000, "oscillator word");
      check(node_khz, 32'd500000 >> q, "node word");
    end
    // 50 mhz divided reference, range 5, 700 mhz oscillator
    bus_write(CFG0_OFS, 32'h0050010d);
    cycles(2);
    check(osc_khz, 32'd700000, "oscillator word at top of its range");
    check(node_khz, 32'd700000, "node word at unity output divider");
    bus_write(CTRL_OFS, 32'h8000000c);
    cycles(2);
    check(node_khz, 32'd100000, "node word under bypass");
    bus_write(CTRL_OFS, 32'h8000000f);
    cycles(2);
    check(node_khz, 32'd0, "node word under reset");
    $display("test config done");
  endtask : test_cfg

  // src: 0 reference, 1 stage 0 core, 2 stage 1 core; lo and hi pack node, final, inverted
  task automatic path_case(input logic [31:0] c, input int src, input logic [2:0] lo,
                           input logic [2:0] hi, input int lag);
    bus_write(CTRL_OFS, c);
    @(posedge clk_i) {ref_lvl, core0_clk_i, core1_clk_i} <= 3'b000;
    cycles(3);
    check({29'h0, node, fin, finb}, {29'h0, lo}, "levels with sources low");
    @(posedge clk_i) begin
      ref_lvl     <= (src == 0);
      core0_clk_i <= (src == 1);
      core1_clk_i <= (src == 2);
    end
    cycles(lag);
    check({29'h0, node, fin, finb}, {29'h0, hi}, "levels with source high");
  endtask : path_case

  task automatic test_path();
    path_case(32'h8000000c, 0, 3'b001, 3'b110, 2);
    path_case(32'h8000000c, 1, 3'b001, 3'b001, 2);
    path_case(32'h80000008, 1, 3'b001, 3'b110, 2);
    path_case(32'h80000008, 0, 3'b001, 3'b001, 2);
    path_case(32'h80000004, 2, 3'b001, 3'b010, 1);
    path_case(32'h8000000e, 0, 3'b000, 3'b100, 2);
    path_case(32'h8000000d, 0, 3'b001, 3'b001, 2);
    @(posedge clk_i) ref_lvl <= 1'b0;
    $display("test clock path done");
  endtask : test_path

  task automatic test_gate();
    logic prev;
    bus_write(CTRL_OFS, 32'h8000000c);
    @(posedge clk_i) ref_run <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      cycles(1);
      check({30'h0, dclk, drun}, 32'h0, "derived clock while gated");
    end
    bus_write(CTRL_OFS, 32'h0000000c);
    wait_run(1'b1);
    for (int i = 0; i < 6; i++) begin
      prev = fin;
      cycles(1);
      check({31'h0, dclk}, {31'h0, prev}, "derived clock follows final output");
    end
    bus_write(CTRL_OFS, 32'h8000000c);
    wait_run(1'b0);
    for (int i = 0; i < 6; i++) begin
      cycles(1);
      check({31'h0, dclk}, 32'h0, "derived clock after gating again");
    end
    @(posedge clk_i) ref_run <= 1'b0;
    $display("test gate done");
  endtask : test_gate

  //////////////////////////////////////////////////////////////////////////
  // main sequence: every input has a value at time zero
  initial begin
    {rst_n_i, wr_i, rd_i, ref_run, ref_lvl, ref_tog, core0_clk_i, core1_clk_i} = 8'h00;
    {lock0_async_i, lock1_async_i} = 2'b00;
    addr_i         = 8'h00;
    wdata_i        = 32'h0;
    ref_freq_khz_i = 32'd100000;
    err_count      = 0;
    check_count    = 0;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    cycles(1);
    test_reset();
    test_ctrl_bits();
    test_lock();
    test_cfg();
    test_path();
    test_gate();
    report_and_stop();
  end
endmodule : system_pll_control_config_tb
